// ==== core/rslh_ctrl.sv ====
// Reference loop input selection, loss revalidation and holdover control
`timescale 1ns/100ps
`include "rslh_regs.svh"
module rslh_ctrl (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [`RSLH_ADDR_W-1:0] reg_addr,
  input wire logic [`RSLH_DATA_W-1:0] reg_wdata,
  output logic [`RSLH_DATA_W-1:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic [3:0] ref_present,
  input wire logic lcm_tick,
  input wire logic phase_error_zero,
  output logic [4:0] buf_enable,
  output logic [4:0] buf_termination,
  output logic [4:0] buf_ac_coupled,
  output logic [4:0] buf_ecl_mode,
  output logic [4:0] buf_high_z,
  output logic [3:0] ref_path_enable,
  output logic [3:0] signal_loss,
  output logic [1:0] selected_ref,
  output logic ref_valid,
  output logic holdover_active,
  output logic divider_reset,
  output logic converter_assist
);

  logic [7:0] buf_reg [0:4];
  logic [7:0] buf_next [0:4];
  logic [7:0] path_reg;
  logic [7:0] path_next;
  logic [7:0] prio_reg;
  logic [7:0] prio_next;
  logic [7:0] losv_reg;
  logic [7:0] losv_next;
  logic [7:0] hexit_reg;
  logic [7:0] hexit_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic [7:0] status;

  logic [4:0] buf_en_reg;
  logic [4:0] buf_term_reg;
  logic [4:0] buf_ac_reg;
  logic [4:0] buf_ecl_reg;
  logic [4:0] buf_hiz_reg;
  logic [4:0] buf_en_next;
  logic [4:0] buf_term_next;
  logic [4:0] buf_ac_next;
  logic [4:0] buf_ecl_next;
  logic [4:0] buf_hiz_next;

  logic [3:0] present_s;
  logic [3:0] loss_w;
  logic [3:0] path_en;
  logic [2:0] pick_ok;
  logic [2:0] pick_raw;
  logic [1:0] crit;
  logic [1:0] act;
  logic exit_now;

  rslh_pkg::rslh_state_e state_reg;
  rslh_pkg::rslh_state_e state_next;
  logic [1:0] sel_reg;
  logic [1:0] sel_next;
  logic valid_reg;
  logic valid_next;
  logic hold_reg;
  logic hold_next;
  logic divrst_reg;
  logic divrst_next;
  logic assist_reg;
  logic assist_next;

  // Map a bus address to a register slot; unmapped gives 4'hf
  function automatic logic [3:0] reg_slot(
      input logic [`RSLH_ADDR_W-1:0] a);
    logic [3:0] s;
    s = 4'hf;
    case (a)
      `RSLH_ADDR_BUF0: s = 4'h0;
      `RSLH_ADDR_BUF1: s = 4'h1;
      `RSLH_ADDR_BUF2: s = 4'h2;
      `RSLH_ADDR_BUF3: s = 4'h3;
      `RSLH_ADDR_BUF4: s = 4'h4;
      `RSLH_ADDR_PATH: s = 4'h5;
      `RSLH_ADDR_PRIO: s = 4'h6;
      `RSLH_ADDR_LOSV: s = 4'h7;
      `RSLH_ADDR_HEXIT: s = 4'h8;
      `RSLH_ADDR_STAT: s = 4'h9;
      default: s = 4'hf;
    endcase
    return s;
  endfunction

  // Register writes; reserved bits are kept as written
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      buf_next[i] = buf_reg[i];
    end
    path_next = path_reg;
    prio_next = prio_reg;
    losv_next = losv_reg;
    hexit_next = hexit_reg;
    if (reg_wr_en) begin
      case (reg_slot(reg_addr))
        4'h0: buf_next[0] = reg_wdata;
        4'h1: buf_next[1] = reg_wdata;
        4'h2: buf_next[2] = reg_wdata;
        4'h3: buf_next[3] = reg_wdata;
        4'h4: buf_next[4] = reg_wdata;
        4'h5: path_next = reg_wdata;
        4'h6: prio_next = reg_wdata;
        4'h7: losv_next = reg_wdata;
        4'h8: hexit_next = reg_wdata;
        default: path_next = path_reg;
      endcase
    end
  end

  // Buffer control fields driven from flops
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      buf_en_next[i] = buf_next[i][`RSLH_BUF_EN_BIT];
      buf_term_next[i] = buf_next[i][`RSLH_MODE_TERM_BIT];
      buf_ac_next[i] = buf_next[i][`RSLH_MODE_AC_BIT];
      buf_ecl_next[i] = buf_next[i][`RSLH_MODE_ECL_BIT];
      buf_hiz_next[i] = buf_next[i][`RSLH_MODE_HIZ_BIT];
    end
  end

  // Status and read data
  always_comb begin
    status = {valid_reg, hold_reg, sel_reg, loss_w};
    rd_valid_next = reg_rd_en;
    rdata_next = rdata_reg;
    if (reg_rd_en) begin
      case (reg_slot(reg_addr))
        4'h0: rdata_next = buf_reg[0];
        4'h1: rdata_next = buf_reg[1];
        4'h2: rdata_next = buf_reg[2];
        4'h3: rdata_next = buf_reg[3];
        4'h4: rdata_next = buf_reg[4];
        4'h5: rdata_next = path_reg;
        4'h6: rdata_next = prio_reg;
        4'h7: rdata_next = losv_reg;
        4'h8: rdata_next = hexit_reg;
        4'h9: rdata_next = status;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < 5; i++) begin
        buf_reg[i] <= `RSLH_RST_BUF;
      end
      path_reg <= `RSLH_RST_PATH;
      prio_reg <= `RSLH_RST_PRIO;
      losv_reg <= `RSLH_RST_LOSV;
      hexit_reg <= `RSLH_RST_HEXIT;
      rdata_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
      buf_en_reg <= 5'h00;
      buf_term_reg <= 5'h00;
      buf_ac_reg <= 5'h00;
      buf_ecl_reg <= 5'h00;
      buf_hiz_reg <= 5'h00;
    end else begin
      for (int i = 0; i < 5; i++) begin
        buf_reg[i] <= buf_next[i];
      end
      path_reg <= path_next;
      prio_reg <= prio_next;
      losv_reg <= losv_next;
      hexit_reg <= hexit_next;
      rdata_reg <= rdata_next;
      rd_valid_reg <= rd_valid_next;
      buf_en_reg <= buf_en_next;
      buf_term_reg <= buf_term_next;
      buf_ac_reg <= buf_ac_next;
      buf_ecl_reg <= buf_ecl_next;
      buf_hiz_reg <= buf_hiz_next;
    end
  end

  rslh_sync2 u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(ref_present),
    .sync_out(present_s)
  );

  // One revalidation timer per reference input
  for (genvar g = 0; g < 4; g++) begin : g_los
    rslh_los_timer u_timer (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .present(present_s[g]),
      .lcm_tick(lcm_tick),
      .hyst_code(losv_reg[`RSLH_LOSV_LSB +: 3]),
      .other_loss(|(loss_w & ~(4'h1 << g))),
      .signal_loss(loss_w[g])
    );
  end

  // Priority selection and holdover state machine
  always_comb begin
    path_en = path_reg[`RSLH_PATH_LSB +: 4];
    pick_ok = rslh_pkg::pick_ref(prio_reg,
      path_en & ~loss_w);
    pick_raw = rslh_pkg::pick_ref(prio_reg, path_en & present_s);
    crit = hexit_reg[`RSLH_CRIT_LSB +: 2];
    act = hexit_reg[`RSLH_ACT_LSB +: 2];
    case (crit)
      2'h1: exit_now = pick_ok[2] && phase_error_zero;
      2'h3: exit_now = pick_raw[2];
      default: exit_now = pick_ok[2];
    endcase
    state_next = state_reg;
    sel_next = sel_reg;
    divrst_next = 1'b0;
    assist_next = 1'b0;
    case (state_reg)
      rslh_pkg::RSLH_TRACK: begin
        if (pick_ok[2]) begin
          sel_next = pick_ok[1:0];
        end else if (crit == 2'h3 && pick_raw[2]) begin
          sel_next = pick_raw[1:0];
        end else begin
          state_next = rslh_pkg::RSLH_HOLD;
        end
      end
      rslh_pkg::RSLH_HOLD: begin
        if (exit_now) begin
          state_next = rslh_pkg::RSLH_TRACK;
          sel_next = pick_ok[2] ? pick_ok[1:0] : pick_raw[1:0];
          case (rslh_pkg::rslh_action_e'(act))
            rslh_pkg::RSLH_ACT_RESET_DIV: divrst_next = 1'b1;
            rslh_pkg::RSLH_ACT_ASSIST: assist_next = 1'b1;
            default: divrst_next = 1'b0;
          endcase
        end
      end
      default: state_next = rslh_pkg::RSLH_HOLD;
    endcase
    hold_next = (state_next == rslh_pkg::RSLH_HOLD);
    valid_next = !hold_next;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= rslh_pkg::RSLH_HOLD;
      sel_reg <= 2'h0;
      valid_reg <= 1'b0;
      hold_reg <= 1'b1;
      divrst_reg <= 1'b0;
      assist_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sel_reg <= sel_next;
      valid_reg <= valid_next;
      hold_reg <= hold_next;
      divrst_reg <= divrst_next;
      assist_reg <= assist_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rd_valid = rd_valid_reg;
  assign buf_enable = buf_en_reg;
  assign buf_termination = buf_term_reg;
  assign buf_ac_coupled = buf_ac_reg;
  assign buf_ecl_mode = buf_ecl_reg;
  assign buf_high_z = buf_hiz_reg;
  assign ref_path_enable = path_reg[`RSLH_PATH_LSB +: 4];
  assign signal_loss = loss_w;
  assign selected_ref = sel_reg;
  assign ref_valid = valid_reg;
  assign holdover_active = hold_reg;
  assign divider_reset = divrst_reg;
  assign converter_assist = assist_reg;

endmodule // rslh_ctrl

// ==== core/rslh_regs.svh ====
// Register offsets, field positions, reset values and revalidation multipliers of the block
`ifndef RSLH_REGS_SVH
`define RSLH_REGS_SVH

`define RSLH_ADDR_W 16
`define RSLH_DATA_W 8

`define RSLH_ADDR_PATH 16'h0005
`define RSLH_ADDR_BUF0 16'h000a
`define RSLH_ADDR_BUF1 16'h000b
`define RSLH_ADDR_BUF2 16'h000c
`define RSLH_ADDR_BUF3 16'h000d
`define RSLH_ADDR_BUF4 16'h000e
`define RSLH_ADDR_PRIO 16'h0014
`define RSLH_ADDR_LOSV 16'h0015
`define RSLH_ADDR_HEXIT 16'h0016
`define RSLH_ADDR_STAT 16'h0020

`define RSLH_BUF_EN_BIT 0
`define RSLH_MODE_TERM_BIT 1
`define RSLH_MODE_AC_BIT 2
`define RSLH_MODE_ECL_BIT 3
`define RSLH_MODE_HIZ_BIT 4

`define RSLH_PATH_LSB 0
`define RSLH_PRIO1_LSB 0
`define RSLH_PRIO2_LSB 2
`define RSLH_PRIO3_LSB 4
`define RSLH_PRIO4_LSB 6
`define RSLH_LOSV_LSB 0
`define RSLH_CRIT_LSB 0
`define RSLH_ACT_LSB 2

`define RSLH_RST_BUF 8'h00
`define RSLH_RST_PATH 8'h00
`define RSLH_RST_PRIO 8'he4
`define RSLH_RST_LOSV 8'h00
`define RSLH_RST_HEXIT 8'h00

`define RSLH_REVAL_ALONE 2'h2
`define RSLH_REVAL_SHARED 2'h3

`endif

// ==== core/rslh_pkg.sv ====
// Types and shared decode functions of the reference selection block
package rslh_pkg;

  typedef enum logic {RSLH_TRACK, RSLH_HOLD} rslh_state_e;

  typedef enum logic [1:0] {
    RSLH_ACT_RESET_DIV = 2'h0,
    RSLH_ACT_NONE_A = 2'h1,
    RSLH_ACT_NONE_B = 2'h2,
    RSLH_ACT_ASSIST = 2'h3
  } rslh_action_e;

  // Hysteresis code to common-multiple cycles: 0 none, else 2^code
  function automatic logic [7:0] hyst_cycles(input logic [2:0] code);
    logic [7:0] v;
    v = 8'h00;
    if (code != 3'h0) begin
      v = 8'h01 << code;
    end
    return v;
  endfunction

  // Walk the four priority fields; first input present in mask wins
  function automatic logic [2:0] pick_ref(input logic [7:0] prio,
                                          input logic [3:0] mask);
    logic [2:0] r;
    logic [1:0] idx;
    r = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      idx = prio[2*i +: 2];
      if (mask[idx]) begin
        r = {1'b1, idx};
      end
    end
    return r;
  endfunction

endpackage

// ==== core/rslh_sync2.sv ====
// Two-flop synchroniser for the reference presence pins
`timescale 1ns/100ps
module rslh_sync2 (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] async_in,
  output logic [3:0] sync_out
);

  logic [3:0] meta_reg;
  logic [3:0] meta_next;
  logic [3:0] sync_reg;
  logic [3:0] sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_reg <= 4'h0;
      sync_reg <= 4'h0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule // rslh_sync2

// ==== core/rslh_los_timer.sv ====
// Per-input signal loss flag with revalidation hysteresis
`timescale 1ns/100ps
`include "rslh_regs.svh"
module rslh_los_timer (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic present,
  input wire logic lcm_tick,
  input wire logic [2:0] hyst_code,
  input wire logic other_loss,
  output logic signal_loss
);

  logic loss_reg;
  logic loss_next;
  logic [9:0] cnt_reg;
  logic [9:0] cnt_next;
  logic [9:0] target;
  logic [1:0] mult;

  always_comb begin
    mult = other_loss ? `RSLH_REVAL_SHARED : `RSLH_REVAL_ALONE;
    target = 10'(rslh_pkg::hyst_cycles(hyst_code)) * 10'(mult);
    loss_next = loss_reg;
    cnt_next = cnt_reg;
    if (!present) begin
      loss_next = 1'b1;
      cnt_next = 10'h000;
    end else if (loss_reg) begin
      if (hyst_code == 3'h0) begin
        loss_next = 1'b0;
      end else if (lcm_tick) begin
        cnt_next = cnt_reg + 10'h001;
        if (cnt_next >= target) begin
          loss_next = 1'b0;
          cnt_next = 10'h000;
        end
      end
    end else begin
      cnt_next = 10'h000;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      loss_reg <= 1'b1;
      cnt_reg <= 10'h000;
    end else begin
      loss_reg <= loss_next;
      cnt_reg <= cnt_next;
    end
  end

  assign signal_loss = loss_reg;

endmodule // rslh_los_timer

// ==== bench/rslh_ctrl_checker.sv ====
// Port assertions of the reference selection block
`timescale 1ns/100ps
`include "rslh_regs.svh"
module rslh_ctrl_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  input wire logic [3:0] ref_present,
  input wire logic lcm_tick,
  input wire logic [4:0] buf_enable,
  input wire logic [4:0] buf_termination,
  input wire logic [4:0] buf_ac_coupled,
  input wire logic [4:0] buf_ecl_mode,
  input wire logic [4:0] buf_high_z,
  input wire logic [3:0] ref_path_enable,
  input wire logic [3:0] signal_loss,
  input wire logic [1:0] selected_ref,
  input wire logic ref_valid,
  input wire logic holdover_active,
  input wire logic divider_reset,
  input wire logic converter_assist
);
  logic [1:0] act_q;
  logic [2:0] losv_q;
  logic [1:0] crit_q;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // Shadow of the exit action and hysteresis code
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      act_q <= 2'h0;
      losv_q <= 3'h0;
      crit_q <= 2'h0;
    end else if (reg_wr_en && reg_addr == `RSLH_ADDR_HEXIT) begin
      act_q <= reg_wdata[3:2];
      crit_q <= reg_wdata[1:0];
    end else if (reg_wr_en && reg_addr == `RSLH_ADDR_LOSV) begin
      losv_q <= reg_wdata[2:0];
    end
  end
  sequence s_rd_req;
    reg_rd_en;
  endsequence
  sequence s_rd_ans;
    reg_rd_valid;
  endsequence
  chk_rd_answer: assert property (s_rd_req |=> s_rd_ans)
    else $error("read not answered next cycle");
  chk_rd_cause: assert property (reg_rd_valid |-> $past(reg_rd_en))
    else $error("read valid without request");
  chk_rdata_hold: assert property (!reg_rd_valid |-> $stable(reg_rdata))
    else $error("read data moved without read");
  chk_buf_fields: assert property (
    reg_wr_en && reg_addr == `RSLH_ADDR_BUF0 |=> {buf_high_z[0],
    buf_ecl_mode[0], buf_ac_coupled[0], buf_termination[0],
    buf_enable[0]} == $past(reg_wdata[4:0]))
    else $error("buffer fields differ from write");
  chk_path_write: assert property (
    reg_wr_en && reg_addr == `RSLH_ADDR_PATH |=>
    ref_path_enable == $past(reg_wdata[3:0]))
    else $error("path enable differs from write");
  chk_sel_enabled: assert property (
    ref_valid && $stable(ref_path_enable) |->
    ref_path_enable[selected_ref])
    else $error("disabled input selected");
  chk_mode_excl: assert property (holdover_active != ref_valid)
    else $error("holdover and valid disagree");
  chk_sel_free: assert property (ref_valid && crit_q != 2'h3 &&
    $stable(signal_loss) && $stable(ref_path_enable) && $stable(crit_q)
    |-> !signal_loss[selected_ref])
    else $error("selected input is flagged lost");
  chk_exit_action: assert property ($fell(holdover_active) |->
    divider_reset == (act_q == 2'h0) && converter_assist == (act_q == 2'h3))
    else $error("wrong action on holdover exit");
  chk_pulse_cause: assert property (
    divider_reset || converter_assist |-> $fell(holdover_active))
    else $error("action pulse outside holdover exit");
  chk_loss_set: assert property (
    $fell(ref_present[0]) |-> ##3 signal_loss[0])
    else $error("loss not flagged in three cycles");
  chk_clear_tick: assert property (
    $fell(signal_loss[0]) && losv_q != 3'h0 |-> $past(lcm_tick))
    else $error("loss cleared without a tick");
endmodule // rslh_ctrl_checker

bind rslh_ctrl rslh_ctrl_checker u_chk (.*);

// ==== bench/rslh_ctrl_tb.sv ====
// Self-checking bench of the reference selection block
`timescale 1ns/100ps
`include "rslh_regs.svh"
module rslh_ctrl_tb;
  logic clk_sys, rst_n, reg_wr_en, reg_rd_en, lcm_tick, phase_error_zero;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic [3:0] ref_present, ref_path_enable, signal_loss;
  logic [4:0] buf_enable, buf_termination, buf_ac_coupled, buf_ecl_mode;
  logic [4:0] buf_high_z;
  logic [1:0] selected_ref;
  logic reg_rd_valid, ref_valid, holdover_active, divider_reset;
  logic converter_assist;
  int failures, n_compared, n_div, n_assist;

  rslh_ctrl DUT (.*);

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Count action pulses
  always @(posedge clk_sys) begin
    if (divider_reset === 1'b1) begin
      n_div++;
    end
    if (converter_assist === 1'b1) begin
      n_assist++;
    end
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    @(negedge clk_sys);
    cmp({7'h0, reg_rd_valid}, 8'h01);
    cmp(reg_rdata, exp);
  endtask

  task automatic pres(input logic [3:0] p, input logic ph);
    @(posedge clk_sys);
    ref_present <= p;
    phase_error_zero <= ph;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      lcm_tick <= 1'b1;
      @(posedge clk_sys);
      lcm_tick <= 1'b0;
    end
    @(negedge clk_sys);
  endtask

  task automatic complete_run;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    complete_run;
  end

  initial begin
    rst_n = 1'b0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    ref_present = 4'h0;
    lcm_tick = 1'b0;
    phase_error_zero = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    rd(`RSLH_ADDR_PRIO, 8'he4);
    rd(`RSLH_ADDR_HEXIT, 8'h00);
    rd(16'h0030, 8'h00);
    wr(`RSLH_ADDR_STAT, 8'h00);
    rd(`RSLH_ADDR_STAT, 8'h4f);
    for (int k = 0; k < 5; k++) begin
      v = {3'h7, 5'h01 << k};
      rd(`RSLH_ADDR_BUF0 + 16'(k), 8'h00);
      wr(`RSLH_ADDR_BUF0 + 16'(k), v);
      cmp({3'h0, buf_high_z[k], buf_ecl_mode[k], buf_ac_coupled[k],
        buf_termination[k], buf_enable[k]}, v & 8'h1f);
      rd(`RSLH_ADDR_BUF0 + 16'(k), v);
    end
    wr(`RSLH_ADDR_PATH, 8'hff);
    cmp({4'h0, ref_path_enable}, 8'h0f);
    rd(`RSLH_ADDR_PATH, 8'hff);
    $display("test registers done");
    wr(`RSLH_ADDR_LOSV, 8'hf8);
    pres(4'hf, 1'b0);
    cyc(5);
    cmp({4'h0, signal_loss}, 8'h00);
    for (int c = 1; c < 4; c++) begin
      wr(`RSLH_ADDR_LOSV, {5'h1f, 3'(c)});
      pres(4'he, 1'b0);
      cyc(5);
      cmp({4'h0, signal_loss}, 8'h01);
      cmp({6'h0, selected_ref}, 8'h01);
      pres(4'hf, 1'b0);
      cyc(4);
      tick((2 << c) - 1);
      cmp({4'h0, signal_loss}, 8'h01);
      tick(1);
      cmp({4'h0, signal_loss}, 8'h00);
    end
    wr(`RSLH_ADDR_LOSV, 8'hf9);
    pres(4'hc, 1'b0);
    cyc(5);
    cmp({6'h0, selected_ref}, 8'h02);
    pres(4'hd, 1'b0);
    cyc(4);
    tick(5);
    cmp({4'h0, signal_loss}, 8'h03);
    tick(1);
    cmp({4'h0, signal_loss}, 8'h02);
    $display("test revalidation done");
    wr(`RSLH_ADDR_LOSV, 8'h00);
    pres(4'hf, 1'b0);
    wr(`RSLH_ADDR_PRIO, 8'h1b);
    cyc(5);
    cmp({6'h0, selected_ref}, 8'h03);
    for (int i = 3; i > 0; i--) begin
      pres(4'hf >> (4 - i), 1'b0);
      cyc(6);
      cmp({6'h0, selected_ref}, 8'(i - 1));
    end
    pres(4'hf, 1'b0);
    wr(`RSLH_ADDR_PATH, 8'h07);
    cyc(5);
    cmp({6'h0, selected_ref}, 8'h02);
    wr(`RSLH_ADDR_PATH, 8'h0f);
    $display("test priority done");
    wr(`RSLH_ADDR_LOSV, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(`RSLH_ADDR_HEXIT, {4'ha, 2'(i), 2'(i)});
      pres(4'h0, 1'b0);
      cyc(6);
      cmp({7'h0, holdover_active}, 8'h01);
      pres(4'h1, 1'b0);
      cyc(6);
      cmp({7'h0, holdover_active}, {7'h0, i != 3});
      cmp({7'h0, ref_valid}, {7'h0, i == 3});
      tick(6);
      cyc(2);
      cmp({7'h0, holdover_active}, {7'h0, i == 1});
      pres(4'h1, 1'b1);
      cyc(3);
      cmp({7'h0, holdover_active}, 8'h00);
      cmp(8'(n_div), 8'h02);
      cmp(8'(n_assist), {7'h0, i == 3});
    end
    $display("test holdover done");
    complete_run;
  end
endmodule // rslh_ctrl_tb
